// file: shared/ptp_pkg.sv
// ptp_pkg: constants for the four-channel pulse-train position output block.
// assumes a 200 MHz system clock and a 32-bit APB register port with 8-bit byte address.
package ptp_pkg;
   // timing: clock period and the two control cycle lengths
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
   localparam int unsigned CTRL_1MS_NS   = 1000000;
   localparam int unsigned CTRL_4MS_NS   = 4000000;
   localparam int unsigned CYC_1MS       = CTRL_1MS_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_4MS       = CTRL_4MS_NS / CLK_PERIOD_NS;
   // channel count and speed limits
   localparam int unsigned NCH     = 4;
   localparam int unsigned PPS_MIN = 1;
   localparam int unsigned PPS_MAX = 100000;
   // register byte offsets
   localparam logic [7:0] OFS_POS_BASE = 8'h00;
   localparam logic [7:0] OFS_AMOUNT   = 8'h20;
   localparam logic [7:0] OFS_FREQ     = 8'h24;
   localparam logic [7:0] OFS_ACCEL    = 8'h28;
   localparam logic [7:0] OFS_CMD      = 8'h2C;
   localparam logic [7:0] OFS_CFG      = 8'h30;
   localparam logic [7:0] OFS_SRCH     = 8'h34;
   localparam logic [7:0] OFS_CFG_ACT  = 8'h38;
   localparam logic [7:0] OFS_STATUS   = 8'h3C;
   localparam logic [7:0] OFS_RESTART  = 8'h40;
   // command word fields
   localparam int unsigned CMD_CH_LSB = 0;
   localparam int unsigned CMD_ABS    = 2;
   localparam int unsigned CMD_CCW    = 3;
   localparam int unsigned CMD_PDIR   = 4;
   localparam int unsigned CMD_ACCEL  = 5;
   localparam int unsigned CMD_SETPOS = 6;
   localparam int unsigned CMD_STOP   = 7;
   localparam int unsigned CMD_SEARCH = 8;
   localparam int unsigned CMD_MOVE   = 9;
   // configuration fields, reset values
   localparam int unsigned CFG_1MS        = 0;
   localparam int unsigned CFG_LIM_ALWAYS = 1;
   localparam int unsigned CFG_LIM_NO     = 2;
   localparam int unsigned CFG_CLR_ORG    = 3;
   localparam int unsigned CFG_SCURVE     = 4;
   localparam int unsigned CFG_W          = 5;
   localparam logic [4:0]  CFG_RST        = 5'h00;
   localparam logic [16:0] SRCH_RST       = 17'h003E8;
   // status field positions
   localparam int unsigned ST_BUSY = 0;
   localparam int unsigned ST_ORG  = 4;
   localparam int unsigned ST_ERR  = 8;
   localparam int unsigned ST_LIM  = 12;
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_SEARCH} ptp_state_t;
endpackage

// file: design/ptp_pulse_out.sv
// ptp_pulse_out: four pulse-train outputs with position counters, limits and ramps.
// assumes synchronous limit and origin inputs and an APB master on the same clock.
//
// Operation
// - outputs are forward/reverse pulses or pulse plus direction, chosen per command.
// - relative pulse counts range 0 to 7FFFFFFF, in either direction.
// - present position is a signed 32-bit two's-complement value.
// - setting position or finishing origin search makes the origin defined (absolute).
// - without a defined origin only relative coordinates are used.
// - absolute move with undefined origin is rejected and flags an error.
// - each position is read as a high and a low 16-bit word.
// - readable position words change only at the periodic refresh.
// - control cycle is selectable as 1 ms or 4 ms.
// - limits act during origin search only, or always.
// - limit inputs are normally-closed or normally-open by setting.
// - limit with hold option stops output and keeps origin status.
// - limit with clear option stops output and makes origin undefined.
// - origin search speed is a configured value in pulses per second.
// - ramps are linear or S-curve by setting.
// - new settings act only after a restart, never while loaded.
// - output frequency runs 1 to 100000 pps in 1 pps steps.
// - ramp rate 1 to 65535 pps per 4 ms.
`timescale 1ns/10ps
`default_nettype none
module ptp_pulse_out #(
   parameter int unsigned CYC_1MS_P = ptp_pkg::CYC_1MS,
   parameter int unsigned CYC_4MS_P = ptp_pkg::CYC_4MS,
   parameter int unsigned PPS_MAX_P = ptp_pkg::PPS_MAX
) (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic [ptp_pkg::NCH-1:0] cwLimit,
   input  wire logic [ptp_pkg::NCH-1:0] ccwLimit,
   input  wire logic [ptp_pkg::NCH-1:0] originIn,
   output logic      [ptp_pkg::NCH-1:0] pulseLineA,
   output logic      [ptp_pkg::NCH-1:0] pulseLineB
);
   import ptp_pkg::*;

   // refuse parameters the counters and accumulator cannot hold
   if (CYC_1MS_P < 1 || CYC_4MS_P < CYC_1MS_P || CYC_4MS_P > 1048576 ||
       PPS_MAX_P < PPS_MIN || PPS_MAX_P > 131071 || 2 * PPS_MAX_P >= CLK_HZ) begin : g_chk
      $error("ptp_pulse_out: unsupported parameter values");
   end

   logic [31:0]        amount_q;
   logic [16:0]        freqSet_q;
   logic [15:0]        accel_q;
   logic [CFG_W-1:0]   cfgStage_q;
   logic [CFG_W-1:0]   cfgAct_q;
   logic [16:0]        srchStage_q;
   logic [16:0]        srchAct_q;
   logic [19:0]        tickCnt_q;
   logic               tick;
   logic               setupPh;
   logic               wrEn;
   logic               cmdGo;
   logic               restartGo;
   logic [15:0]        stClr;
   logic [31:0]        rdData;
   logic               rdErr;
   logic [16:0]        tgtFreq;
   logic [15:0]        stepCalc;
   logic [15:0]        acc4;

   ptp_state_t         state_q  [NCH];
   logic signed [31:0] pos_q    [NCH];
   logic [31:0]        shadow_q [NCH];
   logic [31:0]        remain_q [NCH];
   logic [31:0]        accPul_q [NCH];
   logic [16:0]        freq_q   [NCH];
   logic [16:0]        target_q [NCH];
   logic [15:0]        step_q   [NCH];
   logic [27:0]        phase_q  [NCH];
   logic [NCH-1:0]     level_q;
   logic [NCH-1:0]     dir_q;
   logic [NCH-1:0]     pdir_q;
   logic [NCH-1:0]     accEn_q;
   logic [NCH-1:0]     origin_q;
   logic [NCH-1:0]     err_q;
   logic [NCH-1:0]     lim_q;

   // apb decode; pready comes one cycle after setup, so every access ends after one wait-free beat
   assign setupPh   = psel & ~penable;
   assign wrEn      = psel & penable & pready & pwrite & ~pslverr;
   assign cmdGo     = wrEn && paddr == OFS_CMD;
   assign restartGo = wrEn && paddr == OFS_RESTART && pwdata[0];
   assign stClr     = (wrEn && paddr == OFS_STATUS) ? pwdata[15:0] : 16'h0000;

   // read mux; position words come from the refreshed copies only
   always_comb begin
      rdData = 32'h00000000;
      rdErr  = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         rdErr = 1'b1;
      end else if (paddr < OFS_AMOUNT) begin
         rdData = paddr[2] ? {16'h0000, shadow_q[paddr[4:3]][31:16]}
                           : {16'h0000, shadow_q[paddr[4:3]][15:0]};
      end else begin
         case (paddr)
            OFS_AMOUNT:  rdData = amount_q;
            OFS_FREQ:    rdData = {15'h0000, freqSet_q};
            OFS_ACCEL:   rdData = {16'h0000, accel_q};
            OFS_CMD:     rdData = 32'h00000000;
            OFS_CFG:     rdData = {27'h0000000, cfgStage_q};
            OFS_SRCH:    rdData = {15'h0000, srchStage_q};
            OFS_CFG_ACT: rdData = {27'h0000000, cfgAct_q};
            OFS_STATUS: begin
               for (int k = 0; k < NCH; k++) begin
                  rdData[ST_BUSY + k] = state_q[k] != S_IDLE;
               end
               rdData[ST_ORG +: NCH] = origin_q;
               rdData[ST_ERR +: NCH] = err_q;
               rdData[ST_LIM +: NCH] = lim_q;
            end
            OFS_RESTART: rdData = 32'h00000000;
            default:     rdErr  = 1'b1;
         endcase
      end
   end

   // apb answer flops; read data is captured in setup so it is steady through access
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready  <= 1'b0;
         prdata  <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready  <= setupPh;
         pslverr <= setupPh & rdErr;
         if (setupPh) begin
            prdata <= pwrite ? 32'h00000000 : rdData;
         end
      end
   end

   // command operand registers and staged settings
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         amount_q    <= 32'h00000000;
         freqSet_q   <= 17'h00001;
         accel_q     <= 16'h0001;
         cfgStage_q  <= CFG_RST;
         srchStage_q <= SRCH_RST;
      end else if (wrEn) begin
         case (paddr)
            OFS_AMOUNT: amount_q    <= pwdata;
            OFS_FREQ:   freqSet_q   <= pwdata[16:0];
            OFS_ACCEL:  accel_q     <= pwdata[15:0];
            OFS_CFG:    cfgStage_q  <= pwdata[CFG_W-1:0];
            OFS_SRCH:   srchStage_q <= pwdata[16:0];
            default:    ;
         endcase
      end
   end

   // staged settings become live only on restart, like a power cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfgAct_q  <= CFG_RST;
         srchAct_q <= SRCH_RST;
      end else if (restartGo) begin
         cfgAct_q  <= cfgStage_q;
         srchAct_q <= srchStage_q;
      end
   end

   // control cycle tick, also the position refresh instant
   assign tick = cfgAct_q[CFG_1MS] ? (tickCnt_q == 20'(CYC_1MS_P - 1))
                                   : (tickCnt_q == 20'(CYC_4MS_P - 1));
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tickCnt_q <= 20'h00000;
      end else begin
         tickCnt_q <= (tick || restartGo) ? 20'h00000 : tickCnt_q + 20'h00001;
      end
   end

   // target speed clamped to the legal range; ramp rate is per 4 ms, so quarter it at 1 ms
   assign tgtFreq  = (freqSet_q == 17'h00000) ? 17'(PPS_MIN) :
                     (freqSet_q > 17'(PPS_MAX_P)) ? 17'(PPS_MAX_P) : freqSet_q;
   assign acc4     = cfgAct_q[CFG_1MS] ? {2'h0, accel_q[15:2]} : accel_q;
   assign stepCalc = (acc4 == 16'h0000) ? 16'h0001 : acc4;

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic               hit;
      logic               running;
      logic               absMode;
      logic [28:0]        phaseSum;
      logic               halfDone;
      logic               stepNow;
      logic               cwAct;
      logic               ccwAct;
      logic               limStop;
      logic signed [32:0] diff;
      logic [32:0]        mag;
      logic               newDir;
      logic [31:0]        newDist;
      logic               badCmd;
      logic               startMove;
      logic               startSearch;
      logic               decel;
      logic [16:0]        quarter;
      logic [15:0]        sStep;
      logic [17:0]        upSum;
      logic [16:0]        upF;
      logic [16:0]        dnF;

      assign hit      = cmdGo && pwdata[CMD_CH_LSB +: 2] == 2'(i);
      assign running  = state_q[i] != S_IDLE;
      assign absMode  = pwdata[CMD_ABS];
      // half-period accumulator: each overflow toggles the line, a rising edge is one pulse
      assign phaseSum = {1'b0, phase_q[i]} + {11'h000, freq_q[i], 1'b0};
      assign halfDone = running && phaseSum >= 29'(CLK_HZ);
      assign stepNow  = halfDone && !level_q[i];
      // open normally-closed contact reads low; only the limit ahead of travel stops motion
      assign cwAct    = cfgAct_q[CFG_LIM_NO] ? cwLimit[i] : ~cwLimit[i];
      assign ccwAct   = cfgAct_q[CFG_LIM_NO] ? ccwLimit[i] : ~ccwLimit[i];
      assign limStop  = running && (cfgAct_q[CFG_LIM_ALWAYS] || state_q[i] == S_SEARCH) &&
                        (dir_q[i] ? ccwAct : cwAct);
      assign diff     = 33'(signed'(amount_q)) - 33'(pos_q[i]);
      assign mag      = diff[32] ? 33'(-diff) : 33'(diff);
      assign newDir   = absMode ? diff[32] : pwdata[CMD_CCW];
      assign newDist  = absMode ? mag[31:0] : amount_q;
      // busy channel, absolute without origin, or count above 7FFFFFFF are refused
      assign badCmd   = hit && pwdata[CMD_MOVE] &&
                        (running || (absMode && !origin_q[i]) || (!absMode && amount_q[31]));
      assign startMove   = hit && pwdata[CMD_MOVE] && !badCmd && newDist != 32'h00000000;
      assign startSearch = hit && pwdata[CMD_SEARCH] && !pwdata[CMD_MOVE] && !running;
      // symmetric ramp: start slowing once the pulses left match those spent speeding up
      assign decel    = remain_q[i] <= accPul_q[i];
      assign quarter  = target_q[i] >> 2;
      assign sStep    = (cfgAct_q[CFG_SCURVE] && (freq_q[i] < quarter ||
                        freq_q[i] > target_q[i] - quarter) && step_q[i] > 16'h0001) ?
                        (step_q[i] >> 1) : step_q[i];
      assign upSum    = {1'b0, freq_q[i]} + {2'h0, sStep};
      assign upF      = (upSum > {1'b0, target_q[i]}) ? target_q[i] : upSum[16:0];
      assign dnF      = (freq_q[i] > {1'b0, sStep}) ? freq_q[i] - {1'b0, sStep} : 17'h00001;

      // motion state, position, origin and sticky flags
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            state_q[i]  <= S_IDLE;
            pos_q[i]    <= 32'sh00000000;
            remain_q[i] <= 32'h00000000;
            accPul_q[i] <= 32'h00000000;
            dir_q[i]    <= 1'b0;
            pdir_q[i]   <= 1'b0;
            accEn_q[i]  <= 1'b0;
            origin_q[i] <= 1'b0;
            err_q[i]    <= 1'b0;
            lim_q[i]    <= 1'b0;
         end else if (restartGo) begin
            state_q[i]  <= S_IDLE;
            pos_q[i]    <= 32'sh00000000;
            origin_q[i] <= 1'b0;
            err_q[i]    <= 1'b0;
            lim_q[i]    <= 1'b0;
         end else begin
            if (stepNow) begin
               pos_q[i] <= dir_q[i] ? pos_q[i] - 32'sh00000001 : pos_q[i] + 32'sh00000001;
               if (state_q[i] == S_RUN) begin
                  remain_q[i] <= remain_q[i] - 32'h00000001;
               end
               if (freq_q[i] < target_q[i] && !decel) begin
                  accPul_q[i] <= accPul_q[i] + 32'h00000001;
               end
            end
            // set wins over a clear in the same cycle
            err_q[i] <= (err_q[i] & ~stClr[ST_ERR + i]) | badCmd;
            lim_q[i] <= (lim_q[i] & ~stClr[ST_LIM + i]) | limStop;
            case (state_q[i])
               S_IDLE: begin
                  if (startMove) begin
                     state_q[i]  <= S_RUN;
                     remain_q[i] <= newDist;
                     accPul_q[i] <= 32'h00000000;
                     dir_q[i]    <= newDir;
                     pdir_q[i]   <= pwdata[CMD_PDIR];
                     accEn_q[i]  <= pwdata[CMD_ACCEL];
                  end else if (startSearch) begin
                     state_q[i] <= S_SEARCH;
                     dir_q[i]   <= 1'b1;
                     pdir_q[i]  <= pwdata[CMD_PDIR];
                     accEn_q[i] <= 1'b0;
                  end else if (hit && pwdata[CMD_SETPOS]) begin
                     pos_q[i]    <= signed'(amount_q);
                     origin_q[i] <= 1'b1;
                  end
               end
               S_RUN: begin
                  if (limStop || (hit && pwdata[CMD_STOP]) ||
                      (halfDone && level_q[i] && remain_q[i] == 32'h00000000)) begin
                     state_q[i] <= S_IDLE;
                  end
               end
               S_SEARCH: begin
                  if (limStop || (hit && pwdata[CMD_STOP])) begin
                     state_q[i] <= S_IDLE;
                  end else if (originIn[i]) begin
                     state_q[i]  <= S_IDLE;
                     pos_q[i]    <= 32'sh00000000;
                     origin_q[i] <= 1'b1;
                  end
               end
               default: state_q[i] <= S_IDLE;
            endcase
            // hold option keeps the origin, clear option drops back to relative
            if (limStop && cfgAct_q[CFG_CLR_ORG]) begin
               origin_q[i] <= 1'b0;
            end
         end
      end

      // speed, ramp and pulse timing
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            freq_q[i]   <= 17'h00000;
            target_q[i] <= 17'h00000;
            step_q[i]   <= 16'h0001;
            phase_q[i]  <= 28'h0000000;
            level_q[i]  <= 1'b0;
         end else if (startMove) begin
            target_q[i] <= tgtFreq;
            step_q[i]   <= stepCalc;
            freq_q[i]   <= (pwdata[CMD_ACCEL] && {1'b0, stepCalc} < tgtFreq) ?
                           {1'b0, stepCalc} : tgtFreq;
            phase_q[i]  <= 28'h0000000;
            level_q[i]  <= 1'b0;
         end else if (startSearch) begin
            freq_q[i]   <= (srchAct_q == 17'h00000) ? 17'(PPS_MIN) :
                           (srchAct_q > 17'(PPS_MAX_P)) ? 17'(PPS_MAX_P) : srchAct_q;
            target_q[i] <= srchAct_q;
            phase_q[i]  <= 28'h0000000;
            level_q[i]  <= 1'b0;
         end else if (!running) begin
            phase_q[i] <= 28'h0000000;
            level_q[i] <= 1'b0;
         end else begin
            if (halfDone) begin
               phase_q[i] <= 28'(phaseSum - 29'(CLK_HZ));
               level_q[i] <= ~level_q[i];
            end else begin
               phase_q[i] <= phaseSum[27:0];
            end
            if (tick && state_q[i] == S_RUN && accEn_q[i]) begin
               freq_q[i] <= decel ? dnF : upF;
            end
         end
      end

      // pin drive and refreshed position copy
      always_ff @(posedge clk or negedge nrst) begin
         if (!nrst) begin
            pulseLineA[i] <= 1'b0;
            pulseLineB[i] <= 1'b0;
            shadow_q[i]   <= 32'h00000000;
         end else begin
            pulseLineA[i] <= level_q[i] & (pdir_q[i] | ~dir_q[i]);
            pulseLineB[i] <= pdir_q[i] ? dir_q[i] : (level_q[i] & dir_q[i]);
            if (tick) begin
               shadow_q[i] <= pos_q[i];
            end
         end
      end

      property p_abs_reject;
         @(posedge clk) disable iff (!nrst)
         (hit && pwdata[CMD_MOVE] && absMode && !origin_q[i] && !running && !restartGo)
            |=> (err_q[i] && state_q[i] == S_IDLE);
      endproperty
      a_abs_reject: assert property (p_abs_reject) else $error("absolute move not rejected");

      property p_cw_count;
         @(posedge clk) disable iff (!nrst)
         (stepNow && !dir_q[i] && !restartGo) |=> pos_q[i] == $past(pos_q[i]) + 32'sh00000001;
      endproperty
      a_cw_count: assert property (p_cw_count) else $error("forward pulse not counted");

      property p_ccw_count;
         @(posedge clk) disable iff (!nrst)
         (stepNow && dir_q[i] && !restartGo) |=> pos_q[i] == $past(pos_q[i]) - 32'sh00000001;
      endproperty
      a_ccw_count: assert property (p_ccw_count) else $error("reverse pulse not counted");

      property p_limit_stop;
         @(posedge clk) disable iff (!nrst)
         limStop |=> state_q[i] == S_IDLE ##1 !level_q[i] ##1 !pulseLineA[i];
      endproperty
      a_limit_stop: assert property (p_limit_stop) else $error("limit did not stop output");

      property p_limit_clear;
         @(posedge clk) disable iff (!nrst)
         (limStop && cfgAct_q[CFG_CLR_ORG]) |=> !origin_q[i];
      endproperty
      a_limit_clear: assert property (p_limit_clear) else $error("origin kept on clear option");

      property p_limit_hold;
         @(posedge clk) disable iff (!nrst)
         (limStop && !cfgAct_q[CFG_CLR_ORG] && !restartGo) |=> origin_q[i] == $past(origin_q[i]);
      endproperty
      a_limit_hold: assert property (p_limit_hold) else $error("origin lost on hold option");

      property p_refresh;
         @(posedge clk) disable iff (!nrst)
         !tick |=> $stable(shadow_q[i]);
      endproperty
      a_refresh: assert property (p_refresh) else $error("position copy moved between refreshes");

      property p_ccw_line;
         @(posedge clk) disable iff (!nrst)
         (running && !pdir_q[i] && !dir_q[i]) |=> !pulseLineB[i];
      endproperty
      a_ccw_line: assert property (p_ccw_line) else $error("reverse line pulsed going forward");

      property p_freq_range;
         @(posedge clk) disable iff (!nrst)
         state_q[i] == S_RUN |-> (freq_q[i] >= 17'(PPS_MIN) && freq_q[i] <= 17'(PPS_MAX_P));
      endproperty
      a_freq_range: assert property (p_freq_range) else $error("frequency out of range");
   end

   property p_cfg_hold;
      @(posedge clk) disable iff (!nrst)
      !restartGo |=> $stable(cfgAct_q) && $stable(srchAct_q);
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed without restart");

endmodule
`default_nettype wire

// file: test/ptp_drive_model.sv
// ptp_drive_model: motor drive at the four pulse outputs, counting steps per axis.
// assumes registered pulse lines on clk; pdir selects pulse plus direction decoding.
`timescale 1ns/10ps
`default_nettype none
module ptp_drive_model (
   input  wire logic [3:0] pulseLineA,
   input  wire logic [3:0] pulseLineB,
   input  wire logic [3:0] pdir,
   input  wire logic       clk,
   input  wire logic       nrst,
   output var  int         steps [4]
);
   logic [3:0] lineA_q;
   logic [3:0] lineB_q;
   // a step lands on a rising edge; the direction level is read at that edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lineA_q <= '0;
         lineB_q <= '0;
         steps <= '{default: 0};
      end else begin
         lineA_q <= pulseLineA;
         lineB_q <= pulseLineB;
         for (int i = 0; i < 4; i++) begin
            if (pulseLineA[i] && !lineA_q[i])
               steps[i] <= steps[i] + ((pdir[i] && pulseLineB[i]) ? -1 : 1);
            else if (pulseLineB[i] && !lineB_q[i] && !pdir[i])
               steps[i] <= steps[i] - 1;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/pulse_train_position_output_tb.sv
// pulse_train_position_output_tb: APB-driven moves checked against the drive and a model.
// assumes shortened control ticks (20/80 cycles) so refreshes come quickly.
`timescale 1ns/10ps
`default_nettype none
module pulse_train_position_output_tb;
   import ptp_pkg::*;
   logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, expPos [4];
   logic [3:0] cwLimit = 4'hF, ccwLimit = 4'hF, originIn = 4'h0, pdir = 4'h0;
   logic [3:0] pulseLineA, pulseLineB;
   int steps [4];
   int errors = 0, comparisons = 0, cyc = 0, seed = 54288, n, s0;
   always #2.5 clk = ~clk;
   ptp_pulse_out #(.CYC_1MS_P(20), .CYC_4MS_P(80)) ptp_pulse_out_i (.clk, .nrst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cwLimit, .ccwLimit,
      .originIn, .pulseLineA, .pulseLineB);
   ptp_drive_model ptp_drive_model_i (.pulseLineA, .pulseLineB, .pdir, .clk, .nrst, .steps);
   task automatic end_sim();
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one APB transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // poll busy with a bound so a stuck channel cannot hang the run
   task automatic waitIdle(input int ch);
      n = 0;
      do begin apb(0, OFS_STATUS, 0); n++; end while (rd[ST_BUSY+ch] !== 1'b0 && n < 5000);
   endtask
   // waits past two refresh ticks, then reads both words
   task automatic chkPos(input int ch);
      repeat (170) @(posedge clk);
      apb(0, 8'(8 * ch), 0);
      chk(rd, {16'h0000, expPos[ch][15:0]});
      apb(0, 8'(8 * ch + 4), 0);
      chk(rd, {16'h0000, expPos[ch][31:16]});
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin
         errors++;
         end_sim();
      end
   end
   initial begin
      expPos = '{default: 32'h0};
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      apb(0, OFS_CFG_ACT, 0);
      chk(rd, 32'h0);
      apb(0, 8'h44, 0);
      chk({31'h0, er}, 32'h1);
      apb(1, OFS_FREQ, PPS_MAX);
      apb(1, OFS_CMD, 32'h204);
      apb(0, OFS_STATUS, 0);
      chk({31'h0, rd[ST_ERR]}, 32'h1);
      apb(1, OFS_AMOUNT, 32'h80000000);
      apb(1, OFS_CMD, 32'h201);
      apb(0, OFS_STATUS, 0);
      chk({31'h0, rd[ST_ERR+1]}, 32'h1);
      apb(1, OFS_STATUS, 32'hFF00);
      // every channel, both methods, both directions, random short counts
      for (int ch = 0; ch < 4; ch++) begin
         v = 32'({$random(seed)} % 3 + 1);
         pdir[ch] <= ch[1];
         apb(1, OFS_AMOUNT, v);
         apb(1, OFS_CMD, 32'h200 | ch | (ch[0] << CMD_CCW) | (ch[1] << CMD_PDIR));
         expPos[ch] = ch[0] ? expPos[ch] - v : expPos[ch] + v;
         waitIdle(ch);
         chk(steps[ch], expPos[ch]);
         chkPos(ch);
      end
      v = {2'b10, 30'($random(seed))};
      apb(1, OFS_AMOUNT, v);
      apb(1, OFS_CMD, 32'h040);
      apb(0, OFS_STATUS, 0);
      chk({31'h0, rd[ST_ORG]}, 32'h1);
      expPos[0] = v;
      chkPos(0);
      s0 = steps[0];
      apb(1, OFS_AMOUNT, v + 2);
      apb(1, OFS_CMD, 32'h204);
      expPos[0] = v + 2;
      waitIdle(0);
      chk(steps[0], s0 + 2);
      chkPos(0);
      apb(1, OFS_CFG, 32'h0E);
      apb(0, OFS_CFG_ACT, 0);
      chk(rd, 32'h0);
      cwLimit <= 4'h0;
      ccwLimit <= 4'h0;
      apb(1, OFS_RESTART, 32'h1);
      apb(0, OFS_CFG_ACT, 0);
      chk(rd, 32'h0E);
      apb(1, OFS_AMOUNT, 32'h0);
      apb(1, OFS_CMD, 32'h040);
      apb(1, OFS_AMOUNT, 32'h3E8);
      apb(1, OFS_CMD, 32'h200);
      repeat (3000) @(posedge clk);
      cwLimit <= 4'h1;
      repeat (4) @(posedge clk);
      chk({30'h0, pulseLineA[0], pulseLineB[0]}, 32'h0);
      apb(0, OFS_STATUS, 0);
      chk({rd[ST_LIM], rd[ST_ORG], rd[ST_BUSY]}, 32'h4);
      end_sim();
   end
endmodule
`default_nettype wire
